// File: rba_pkg.sv
/*
 * Shared constants and types for the register bit access bank.
 * Assumes one system clock, a synchronous active-low hardware reset and a
 * synchronous software reset pulse supplied by the surrounding device.
 */
`default_nettype none

package rba_pkg;

    // ------------------------------------------------------------
    // Word layout
    // ------------------------------------------------------------
    localparam int unsigned REG_WIDTH  = 16;
    localparam int unsigned NUM_FIELDS = 12;

    localparam int unsigned BIT_READ_WRITE      = 0;
    localparam int unsigned BIT_READ_ONLY       = 1;
    localparam int unsigned BIT_WRITE_ONLY      = 2;
    localparam int unsigned BIT_WRITE_ONE_CLEAR = 3;
    localparam int unsigned BIT_WRITE_ANY_CLEAR = 4;
    localparam int unsigned BIT_CLEAR_ON_READ   = 5;
    localparam int unsigned BIT_LATCH_LOW       = 6;
    localparam int unsigned BIT_LATCH_HIGH      = 7;
    localparam int unsigned BIT_SELF_CLEAR      = 8;
    localparam int unsigned BIT_SELF_SET        = 9;
    localparam int unsigned BIT_STICKY_HIGH     = 10;
    localparam int unsigned BIT_KEEP_SOFT       = 11;

    // Latch-low and self-setting bits rest at one.
    localparam logic [REG_WIDTH-1:0] FIELD_RESET = 16'h0240;
    // Bits that survive a software reset.
    localparam logic [REG_WIDTH-1:0] KEEP_MASK   = 16'h0800;

    // ------------------------------------------------------------
    // Access behaviours
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ACC_READ_WRITE         = 4'h0,
        ACC_READ_ONLY          = 4'h1,
        ACC_WRITE_ONLY         = 4'h2,
        ACC_WRITE_ONE_CLEAR    = 4'h3,
        ACC_WRITE_ANY_TO_CLEAR = 4'h4,
        ACC_CLEAR_ON_READ      = 4'h5,
        ACC_LATCH_LOW          = 4'h6,
        ACC_LATCH_HIGH         = 4'h7,
        ACC_SELF_CLEARING      = 4'h8,
        ACC_SELF_SETTING       = 4'h9,
        ACC_STICKY_HIGH        = 4'hA
    } rba_access_t;

    typedef struct packed {
        logic q;
    } rba_field_state_t;

    typedef struct packed {
        logic [REG_WIDTH-1:0] rd_data;
        logic                 rd_valid;
    } rba_bank_state_t;

    function automatic rba_access_t rba_field_access(input int unsigned idx);
        case (idx)
            BIT_READ_ONLY:       return ACC_READ_ONLY;
            BIT_WRITE_ONLY:      return ACC_WRITE_ONLY;
            BIT_WRITE_ONE_CLEAR: return ACC_WRITE_ONE_CLEAR;
            BIT_WRITE_ANY_CLEAR: return ACC_WRITE_ANY_TO_CLEAR;
            BIT_CLEAR_ON_READ:   return ACC_CLEAR_ON_READ;
            BIT_LATCH_LOW:       return ACC_LATCH_LOW;
            BIT_LATCH_HIGH:      return ACC_LATCH_HIGH;
            BIT_SELF_CLEAR:      return ACC_SELF_CLEARING;
            BIT_SELF_SET:        return ACC_SELF_SETTING;
            BIT_STICKY_HIGH:     return ACC_STICKY_HIGH;
            default:             return ACC_READ_WRITE;
        endcase
    endfunction

endpackage

`default_nettype wire

// File: rba_field.sv
/*
 * One storage bit with a selectable access behaviour.
 * Assumes write and read strobes are one-cycle pulses on clk_sys and that
 * hardware event and condition inputs are synchronous to clk_sys.
 */
`default_nettype none

module rba_field
    import rba_pkg::*;
#(
    parameter rba_access_t ACCESS    = ACC_READ_WRITE,
    parameter logic        RESET_VAL = 1'h0,
    parameter logic        KEEP      = 1'h0
) (
    // Clock and resets
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic soft_rst,
    // Software access
    input  wire logic wr_en,
    input  wire logic wr_bit,
    input  wire logic rd_en,
    // Hardware side
    input  wire logic hw_set,
    input  wire logic hw_cond,
    output logic      q
);

    localparam rba_field_state_t RESET_STATE = '{q: RESET_VAL};

    rba_field_state_t state;
    rba_field_state_t next_state;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (ACCESS)
            ACC_READ_WRITE, ACC_WRITE_ONLY: begin
                if (wr_en) begin
                    next_state.q = wr_bit;
                end
            end
            ACC_READ_ONLY: begin
                next_state.q = hw_cond;
            end
            ACC_WRITE_ONE_CLEAR: begin
                // The event is applied last so that it wins over a clear.
                if (wr_en && wr_bit) begin
                    next_state.q = 1'h0;
                end
                if (hw_set) begin
                    next_state.q = 1'h1;
                end
            end
            ACC_WRITE_ANY_TO_CLEAR: begin
                if (wr_en) begin
                    next_state.q = 1'h0;
                end
                if (hw_set) begin
                    next_state.q = 1'h1;
                end
            end
            ACC_CLEAR_ON_READ, ACC_LATCH_HIGH: begin
                if (rd_en) begin
                    next_state.q = 1'h0;
                end
                if (hw_set) begin
                    next_state.q = 1'h1;
                end
            end
            ACC_LATCH_LOW: begin
                // A low seen during the read cycle stays latched.
                next_state.q = rd_en ? hw_cond : (state.q & hw_cond);
            end
            ACC_STICKY_HIGH: begin
                next_state.q = rd_en ? hw_cond : (state.q | hw_cond);
            end
            ACC_SELF_CLEARING: begin
                next_state.q = 1'h0;
                if (wr_en && wr_bit) begin
                    next_state.q = 1'h1;
                end
            end
            ACC_SELF_SETTING: begin
                next_state.q = 1'h1;
                if (wr_en && !wr_bit) begin
                    next_state.q = 1'h0;
                end
            end
            default: begin
                next_state = state;
            end
        endcase
        if (soft_rst && !KEEP) begin
            next_state = RESET_STATE;
        end
    end

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state <= RESET_STATE;
        end else begin
            state <= next_state;
        end
    end

    assign q = state.q;

endmodule

`default_nettype wire

// File: rba_bank.sv
/*
 * Register word built from bit primitives, one of each access behaviour,
 * with a registered read port and a software reset.
 * Assumes the enclosing device decodes the address and raises wr_en or rd_en
 * for one clk_sys cycle per access to this word.
 */
`default_nettype none

// Notes on behaviour
// - Read-only bit reads its value; writes leave it unchanged.
// - Write-only bit stores writes; its read value is not to be relied on.
// - Write-one-to-clear bit clears on a written one, ignores a zero.
// - Write-any-to-clear field clears on any write, whatever the data.
// - Clear-on-read field returns its value, then clears; writes do nothing.
// - Latch-low bit holds its low until the word is read; read reloads it from its condition.
// - Latch-high bit holds its high until the word is read; read clears it.
// - Self-clearing bit returns to zero by itself; writing zero is ignored.
// - Self-setting bit returns to one by itself; writing one is ignored.
// - Sticky high status stays high until read, then follows its condition.
// - Unread sticky high status stays high though its condition has gone.
// - Bits kept on soft reset change only on hardware reset or writes.

module rba_bank
    import rba_pkg::*;
#(
    parameter int unsigned WIDTH  = REG_WIDTH,
    parameter int unsigned FIELDS = NUM_FIELDS
) (
    // Clock and resets
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic             soft_rst,
    // Software access to the word
    input  wire logic             wr_en,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic             rd_en,
    output logic      [WIDTH-1:0] rd_data,
    output logic                  rd_valid,
    // Hardware events and conditions, one per bit
    input  wire logic [WIDTH-1:0] hw_set,
    input  wire logic [WIDTH-1:0] hw_cond,
    // Current bit values towards the device logic
    output logic      [WIDTH-1:0] field_q
);

    rba_bank_state_t  state;
    rba_bank_state_t  next_state;
    logic [WIDTH-1:0] read_word;

    // ------------------------------------------------------------
    // Bit primitives
    // ------------------------------------------------------------
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        if (i < FIELDS) begin : g_field
            rba_field #(
                .ACCESS    (rba_field_access(i)),
                .RESET_VAL (FIELD_RESET[i]),
                .KEEP      (KEEP_MASK[i])
            ) u_field (
                .clk_sys (clk_sys),
                .rst_n   (rst_n),
                .soft_rst(soft_rst),
                .wr_en   (wr_en),
                .wr_bit  (wr_data[i]),
                .rd_en   (rd_en),
                .hw_set  (hw_set[i]),
                .hw_cond (hw_cond[i]),
                .q       (field_q[i])
            );
            // Write-only data is hidden on reads so software cannot lean on it.
            if (rba_field_access(i) == ACC_WRITE_ONLY) begin : g_hide
                assign read_word[i] = 1'h0;
            end else begin : g_show
                assign read_word[i] = field_q[i];
            end
        end else begin : g_reserved
            // Reserved bits hold no state: writes are dropped and reads give zero.
            assign field_q[i]   = 1'h0;
            assign read_word[i] = 1'h0;
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    // The word is captured on the same edge that clears the read-sensitive
    // bits, so the read returns the value from before the clear.
    always_comb begin
        next_state          = state;
        next_state.rd_valid = rd_en;
        if (rd_en) begin
            next_state.rd_data = read_word;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign rd_data  = state.rd_data;
    assign rd_valid = state.rd_valid;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_read_only_hold: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !soft_rst |=> field_q[BIT_READ_ONLY] == $past(hw_cond[BIT_READ_ONLY])
    ) else $error("read-only bit did not follow its source");

    chk_write_only_hidden: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        rd_en && !soft_rst |=> rd_valid && rd_data[BIT_WRITE_ONLY] == 1'h0
    ) else $error("write-only bit leaked onto the read port");

    chk_write_only_store: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        wr_en && !soft_rst |=> field_q[BIT_WRITE_ONLY] == $past(wr_data[BIT_WRITE_ONLY])
    ) else $error("write-only bit did not take the written value");

    chk_w1c_clear: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        wr_en && wr_data[BIT_WRITE_ONE_CLEAR] && !hw_set[BIT_WRITE_ONE_CLEAR] && !soft_rst
        |=> !field_q[BIT_WRITE_ONE_CLEAR]
    ) else $error("write-one-to-clear bit not cleared");

    chk_w1c_zero_kept: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        field_q[BIT_WRITE_ONE_CLEAR] && !(wr_en && wr_data[BIT_WRITE_ONE_CLEAR]) && !soft_rst
        |=> field_q[BIT_WRITE_ONE_CLEAR]
    ) else $error("write-one-to-clear bit lost without a written one");

    chk_w1c_set_wins: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        hw_set[BIT_WRITE_ONE_CLEAR] && !soft_rst |=> field_q[BIT_WRITE_ONE_CLEAR]
    ) else $error("event lost against a write-one clear");

    chk_any_write_clear: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        wr_en && !hw_set[BIT_WRITE_ANY_CLEAR] && !soft_rst
        |=> !field_q[BIT_WRITE_ANY_CLEAR]
    ) else $error("write-any-to-clear field not cleared by a write");

    chk_any_clear_kept: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        field_q[BIT_WRITE_ANY_CLEAR] && !wr_en && !soft_rst |=> field_q[BIT_WRITE_ANY_CLEAR]
    ) else $error("write-any-to-clear field lost without a write");

    chk_cor_read_value: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        rd_en && !soft_rst
        |=> rd_data[BIT_CLEAR_ON_READ] == $past(field_q[BIT_CLEAR_ON_READ])
            && field_q[BIT_CLEAR_ON_READ] == $past(hw_set[BIT_CLEAR_ON_READ])
    ) else $error("clear-on-read field returned or cleared wrongly");

    chk_cor_write_none: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        field_q[BIT_CLEAR_ON_READ] && wr_en && !rd_en && !soft_rst
        |=> field_q[BIT_CLEAR_ON_READ]
    ) else $error("write disturbed a clear-on-read field");

    chk_latch_low_hold: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !field_q[BIT_LATCH_LOW] && !rd_en && !soft_rst
        ##0 hw_cond[BIT_LATCH_LOW] [*1]
        |=> !field_q[BIT_LATCH_LOW]
    ) else $error("latch-low bit released before a read");

    chk_latch_low_read: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        rd_en && !soft_rst |=> field_q[BIT_LATCH_LOW] == $past(hw_cond[BIT_LATCH_LOW])
    ) else $error("latch-low bit not refreshed by a read");

    chk_latch_high_hold: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        field_q[BIT_LATCH_HIGH] && !rd_en && !soft_rst |=> field_q[BIT_LATCH_HIGH]
    ) else $error("latch-high bit released before a read");

    chk_latch_high_read: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        rd_en && !hw_set[BIT_LATCH_HIGH] && !soft_rst |=> !field_q[BIT_LATCH_HIGH]
    ) else $error("latch-high bit not cleared by a read");

    chk_self_clear_pulse: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        wr_en && wr_data[BIT_SELF_CLEAR] && !soft_rst
        ##1 !(wr_en && wr_data[BIT_SELF_CLEAR])
        |-> field_q[BIT_SELF_CLEAR] ##1 !field_q[BIT_SELF_CLEAR]
    ) else $error("self-clearing bit did not pulse for one cycle");

    chk_self_clear_zero: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !(wr_en && wr_data[BIT_SELF_CLEAR]) |=> !field_q[BIT_SELF_CLEAR]
    ) else $error("self-clearing bit set without a written one");

    chk_self_set_return: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !(wr_en && !wr_data[BIT_SELF_SET]) |=> field_q[BIT_SELF_SET]
    ) else $error("self-setting bit did not return to one");

    chk_self_set_clear: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        wr_en && !wr_data[BIT_SELF_SET] && !soft_rst |=> !field_q[BIT_SELF_SET]
    ) else $error("self-setting bit ignored a written zero");

    chk_sticky_follow: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        rd_en && !soft_rst
        |=> field_q[BIT_STICKY_HIGH] == $past(hw_cond[BIT_STICKY_HIGH])
            && rd_data[BIT_STICKY_HIGH] == $past(field_q[BIT_STICKY_HIGH])
    ) else $error("sticky status wrong after a read");

    chk_sticky_unread: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (field_q[BIT_STICKY_HIGH] && !rd_en && !soft_rst) [*2]
        |=> field_q[BIT_STICKY_HIGH]
    ) else $error("unread sticky status dropped");

    chk_keep_on_soft: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        soft_rst && !wr_en |=> $stable(field_q[BIT_KEEP_SOFT])
    ) else $error("kept bit changed on a software reset");

    chk_soft_defaults: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        soft_rst
        |=> field_q[BIT_READ_WRITE] == FIELD_RESET[BIT_READ_WRITE]
            && field_q[BIT_SELF_SET] == FIELD_RESET[BIT_SELF_SET]
            && field_q[BIT_LATCH_LOW] == FIELD_RESET[BIT_LATCH_LOW]
    ) else $error("software reset did not load defaults");

    chk_hard_defaults: assert property (
        @(posedge clk_sys)
        !rst_n |=> field_q == FIELD_RESET && !rd_valid
    ) else $error("hardware reset did not load defaults");

    chk_reserved_zero: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        rd_valid |-> (rd_data >> FIELDS) == '0
    ) else $error("reserved bits read non-zero");

    chk_read_only_read: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        rd_en |=> rd_data[BIT_READ_ONLY] == $past(field_q[BIT_READ_ONLY])
    ) else $error("read-only bit read back wrongly");

    chk_read_valid_once: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !rd_en |=> !rd_valid
    ) else $error("read valid without a read");

    chk_read_data_hold: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !rd_en |=> $stable(rd_data)
    ) else $error("read data changed without a read");

    // A set that meets a clear in one cycle must win, or an event would be lost.
    chk_any_set_wins: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        hw_set[BIT_WRITE_ANY_CLEAR] && !soft_rst
        |=> field_q[BIT_WRITE_ANY_CLEAR]
    ) else $error("event lost against a write-any clear");

    chk_cor_set_wins: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        hw_set[BIT_CLEAR_ON_READ] && !soft_rst
        |=> field_q[BIT_CLEAR_ON_READ]
    ) else $error("event lost against a clearing read");

    chk_latch_high_set: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        hw_set[BIT_LATCH_HIGH] && !soft_rst |=> field_q[BIT_LATCH_HIGH]
    ) else $error("latch-high bit missed its event");

    chk_latch_low_catch: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !hw_cond[BIT_LATCH_LOW] && !soft_rst
        |=> !field_q[BIT_LATCH_LOW]
    ) else $error("latch-low bit missed a low condition");

    chk_sticky_catch: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        hw_cond[BIT_STICKY_HIGH] && !soft_rst |=> field_q[BIT_STICKY_HIGH]
    ) else $error("sticky status missed its condition");

    chk_keep_takes_write: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        wr_en |=> field_q[BIT_KEEP_SOFT] == $past(wr_data[BIT_KEEP_SOFT])
    ) else $error("kept bit did not take a write");

    chk_self_clear_set: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        wr_en && wr_data[BIT_SELF_CLEAR] && !soft_rst |=> field_q[BIT_SELF_CLEAR]
    ) else $error("self-clearing bit ignored a written one");

endmodule

`default_nettype wire

// File: tb_register_bit_access_types.sv
/*
 * Self-checking testbench for the register bit access bank (rba_bank).
 * Assumes rba_pkg is compiled first and that the bank keeps its default
 * width and fixed bit map; every input is driven here with no partner model.
 */
`default_nettype none

// ------------------------------------------------------------
// Comparison helper
// ------------------------------------------------------------
`define rba_check(what, exp, got) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) begin \
            bad_count++; \
            $display("BAD %s expected %h seen %h", what, exp, got); \
        end \
    end

module tb_register_bit_access_types
    import rba_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    // Bit 6 condition rests high so the latch-low bit is not tripped by idle cycles.
    localparam logic [15:0] COND_IDLE = 16'h0040;

    logic        clk_sys  = 1'b0;
    logic        rst_n    = 1'b0;
    logic        soft_rst = 1'b0;
    logic        wr_en    = 1'b0;
    logic [15:0] wr_data  = 16'h0000;
    logic        rd_en    = 1'b0;
    logic [15:0] hw_set   = 16'h0000;
    logic [15:0] hw_cond  = COND_IDLE;
    logic [15:0] cond     = COND_IDLE;
    logic [15:0] rd_data;
    logic        rd_valid;
    logic [15:0] field_q;
    int          bad_count  = 0;
    int          n_compared = 0;

    rba_bank dut_u (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .soft_rst (soft_rst),
        .wr_en    (wr_en),
        .wr_data  (wr_data),
        .rd_en    (rd_en),
        .rd_data  (rd_data),
        .rd_valid (rd_valid),
        .hw_set   (hw_set),
        .hw_cond  (hw_cond),
        .field_q  (field_q)
    );

    initial begin
        forever #50 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------
    // Drivers
    // ------------------------------------------------------------
    // Inputs set here are taken at the following edge; outputs looked at
    // after a call show the edge that took the previous call's inputs.
    task automatic cyc(input logic we, input logic [15:0] wd, input logic re,
                       input logic [15:0] hs);
        @(posedge clk_sys);
        wr_en    <= we;
        wr_data  <= wd & 16'h0FFF;
        rd_en    <= re;
        hw_set   <= hs;
        hw_cond  <= cond;
        soft_rst <= 1'b0;
        #1;
    endtask

    task automatic idle();
        cyc(1'b0, 16'h0000, 1'b0, 16'h0000);
    endtask

    task automatic rd();
        cyc(1'b0, 16'h0000, 1'b1, 16'h0000);
    endtask

    // Writes keep bit 9 high unless a test means to clear the self-setting bit.
    task automatic wr(input logic [15:0] wd);
        cyc(1'b1, wd | 16'h0200, 1'b0, 16'h0000);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        `rba_check("reset word", 16'h0240, field_q)
        `rba_check("reset valid", 1'b0, rd_valid)
        $display("test reset done");
    endtask

    task automatic t_read_only();
        cond = 16'h0042;
        idle();
        idle();
        `rba_check("ro follows cond", 1'b1, field_q[1])
        cyc(1'b1, 16'h0200, 1'b0, 16'h0000);
        idle();
        `rba_check("ro after write 0", 1'b1, field_q[1])
        rd();
        idle();
        `rba_check("ro read", 1'b1, rd_data[1])
        cond = COND_IDLE;
        wr(16'h0002);
        idle();
        `rba_check("ro after write 1", 1'b0, field_q[1])
        $display("test read_only done");
    endtask

    task automatic t_write_only();
        wr(16'h0005);
        idle();
        `rba_check("wo stored", 1'b1, field_q[2])
        rd();
        idle();
        // Bit 2 and the reserved bits are left out: their read value is not relied on.
        `rba_check("rw read", 1'b1, rd_data[0])
        wr(16'h0000);
        idle();
        `rba_check("wo cleared", 2'b00, {field_q[2], field_q[0]})
        $display("test write_only done");
    endtask

    task automatic t_clear_bits();
        cyc(1'b0, 16'h0000, 1'b0, 16'h0018);
        idle();
        `rba_check("w1c and any set", 2'b11, field_q[4:3])
        wr(16'h0000);
        idle();
        `rba_check("w1c keeps on 0", 1'b1, field_q[3])
        `rba_check("any clears on 0", 1'b0, field_q[4])
        wr(16'h0008);
        idle();
        `rba_check("w1c clears on 1", 1'b0, field_q[3])
        $display("test clear_bits done");
    endtask

    task automatic t_clear_on_read();
        cyc(1'b0, 16'h0000, 1'b0, 16'h00A0);
        idle();
        wr(16'h0000);
        idle();
        `rba_check("cor and latch held", 2'b11, {field_q[7], field_q[5]})
        rd();
        rd();
        `rba_check("first read valid", 1'b1, rd_valid)
        `rba_check("first read data", 2'b11, {rd_data[7], rd_data[5]})
        `rba_check("cleared by read", 2'b00, {field_q[7], field_q[5]})
        idle();
        `rba_check("second read valid", 1'b1, rd_valid)
        `rba_check("second read data", 2'b00, {rd_data[7], rd_data[5]})
        idle();
        `rba_check("valid one cycle", 1'b0, rd_valid)
        $display("test clear_on_read done");
    endtask

    task automatic t_latch_low();
        cond = 16'h0000;
        idle();
        cond = COND_IDLE;
        idle();
        idle();
        idle();
        `rba_check("low latch held", 1'b0, field_q[6])
        rd();
        idle();
        `rba_check("low latch read", 1'b0, rd_data[6])
        `rba_check("low latch released", 1'b1, field_q[6])
        $display("test latch_low done");
    endtask

    task automatic t_sticky();
        cond = COND_IDLE | 16'h0400;
        idle();
        cond = COND_IDLE;
        idle();
        idle();
        idle();
        `rba_check("sticky unread", 1'b1, field_q[10])
        rd();
        idle();
        `rba_check("sticky read", 1'b1, rd_data[10])
        `rba_check("sticky gone", 1'b0, field_q[10])
        cond = COND_IDLE | 16'h0400;
        idle();
        rd();
        idle();
        `rba_check("sticky persists", 1'b1, field_q[10])
        cond = COND_IDLE;
        idle();
        idle();
        `rba_check("sticky holds", 1'b1, field_q[10])
        $display("test sticky done");
    endtask

    task automatic t_self();
        cyc(1'b1, 16'h0100, 1'b0, 16'h0000);
        idle();
        `rba_check("self bits moved", 2'b01, field_q[9:8])
        idle();
        `rba_check("both returned", 2'b10, field_q[9:8])
        cyc(1'b1, 16'h0200, 1'b0, 16'h0000);
        idle();
        `rba_check("ignored writes", 2'b10, field_q[9:8])
        $display("test self done");
    endtask

    task automatic t_soft();
        cyc(1'b1, 16'h0A01, 1'b0, 16'h0008);
        idle();
        // The sticky status raised in the sticky test is still unread, so bit 10 stays high.
        `rba_check("before soft", 16'h0E49, field_q)
        @(posedge clk_sys);
        soft_rst <= 1'b1;
        #1;
        idle();
        `rba_check("after soft", 16'h0A40, field_q)
        @(posedge clk_sys);
        rst_n <= 1'b0;
        #1;
        idle();
        `rba_check("after hard", 16'h0240, field_q)
        @(posedge clk_sys);
        rst_n <= 1'b1;
        #1;
        $display("test soft done");
    endtask

    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    task automatic conclude();
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (2000) @(posedge clk_sys);
        bad_count++;
        $display("BAD watchdog expected finish seen hang");
        conclude();
    end

    initial begin
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        #1;
        t_reset();
        t_read_only();
        t_write_only();
        t_clear_bits();
        t_clear_on_read();
        t_latch_low();
        t_sticky();
        t_self();
        t_soft();
        conclude();
    end

endmodule

`undef rba_check

`default_nettype wire
